// ==== verilog/ldcs_sequencer.sv ====
`timescale 1ns/1ps

module ldcs_sequencer
    import ldcs_pkg::*;
#(
    parameter int unsigned PIN_LOW_COUNT   = PIN_LOW_CYCLES,
    parameter int unsigned WAKE_COUNT      = WAKE_CYCLES,
    parameter int unsigned SLEEP_MIN_COUNT = SLEEP_MIN_CYCLES,
    parameter int unsigned SLEEP_MAX_COUNT = SLEEP_MAX_CYCLES
)
(
    input  wire logic               clock,
    input  wire logic               nrst,
    input  wire logic               clock_enable,
    input  wire logic               mosi,
    input  wire logic               sclk,
    input  wire logic               csn,
    input  wire logic               wake_above_rising,
    input  wire logic               wake_above_falling,
    input  wire ldcs_config_type    config_in,
    input  wire logic               pll_locked,
    input  wire logic               logic_self_test,
    input  wire logic               turns_clear,
    input  wire logic               lp_angle_valid,
    input  wire logic [ANGLE_W-1:0] lp_angle,
    input  wire logic               pwm_level,
    input  wire logic               miso_level,
    input  wire logic [2:0]         commutation_level,
    output logic                    pwm_out,
    output logic                    pwm_oe,
    output logic                    miso_out,
    output logic                    miso_oe,
    output logic [2:0]              commutation_outputs,
    output logic                    commutation_oe,
    output ldcs_power_type          power_ctrl,
    output logic                    sample_request,
    output logic                    rotation_direction,
    output logic [ANGLE_W-1:0]      velocity,
    output logic [TURNS_W-1:0]      turns_count,
    output logic                    turns_warning,
    output ldcs_state_type          lpm_state
);

    typedef struct packed {
        ldcs_state_type     st;
        logic [31:0]        period_cnt;
        logic [31:0]        pin_cnt;
        logic [31:0]        wake_cnt;
        logic               pins_low;
        logic [ANGLE_W-1:0] prev_angle;
        logic               have_prev;
        logic [ANGLE_W-1:0] vel;
        logic               fast;
        logic               rot_dir;
        logic               sample;
    } ldcs_seq_type;

    ldcs_seq_type state_reg;
    ldcs_seq_type state_next;
    logic         any_pin_high;
    logic         period_end;
    logic [31:0]  sleep_len;

    assign any_pin_high = mosi | sclk | csn;
    // Clamps the programmed sleep period into its legal range.
    assign sleep_len = (config_in.sleep_cycles < SLEEP_MIN_COUNT) ? SLEEP_MIN_COUNT :
                       (config_in.sleep_cycles > SLEEP_MAX_COUNT) ? SLEEP_MAX_COUNT :
                       config_in.sleep_cycles;
    assign period_end = (state_reg.period_cnt >= sleep_len - 32'h1);

    // Next-state logic for the duty-cycle sequencer.
    always_comb begin
        logic [ANGLE_W-1:0] d;
        logic [ANGLE_W-1:0] mag;
        d          = lp_angle - state_reg.prev_angle;
        mag        = d[ANGLE_W-1] ? (~d + 1'b1) : d;
        state_next = state_reg;
        state_next.sample = 1'b0;

        // Period counter free-runs in every state.
        state_next.period_cnt = period_end ? 32'h0 : state_reg.period_cnt + 32'h1;

        // Debounce of all-low pins; any high pin restarts it.
        if (any_pin_high) begin
            state_next.pin_cnt  = 32'h0;
            state_next.pins_low = 1'b0;
        end else if (state_reg.pin_cnt >= PIN_LOW_COUNT - 1) begin
            state_next.pins_low = 1'b1;
        end else begin
            state_next.pin_cnt = state_reg.pin_cnt + 32'h1;
        end

        // Velocity capture from successive low-power samples.
        if (lp_angle_valid && state_reg.st == LDCS_WAKE) begin
            state_next.prev_angle = lp_angle;
            state_next.have_prev  = 1'b1;
            state_next.vel        = state_reg.have_prev ? mag : '0;
            state_next.fast       = state_reg.have_prev &&
                                    (mag > config_in.velocity_threshold);
            // Direction of the last low-power step; one means decreasing angle.
            if (state_reg.have_prev && d != '0) begin
                state_next.rot_dir = d[ANGLE_W-1];
            end
        end

        if (logic_self_test) begin
            state_next.rot_dir = 1'b0;
        end

        case (state_reg.st)
            LDCS_NORMAL: begin
                state_next.have_prev = 1'b0;
                if (state_reg.pins_low && config_in.lpm_enable && !wake_above_falling) begin
                    state_next.st       = LDCS_WAKE;
                    state_next.wake_cnt = 32'h0;
                    state_next.fast     = 1'b0;
                    state_next.sample   = 1'b1;
                end
            end
            LDCS_WAKE: begin
                if (state_reg.wake_cnt < WAKE_COUNT - 1) begin
                    state_next.wake_cnt = state_reg.wake_cnt + 32'h1;
                end
                if (any_pin_high) begin
                    state_next.st = LDCS_RESUME;
                end else if (period_end && state_reg.wake_cnt >= WAKE_COUNT - 1 &&
                             !state_reg.fast && !wake_above_falling) begin
                    state_next.st = LDCS_SLEEP;
                end else if (period_end) begin
                    state_next.wake_cnt = 32'h0;
                    state_next.sample   = 1'b1;
                end
            end
            LDCS_SLEEP: begin
                if (any_pin_high) begin
                    state_next.st = LDCS_RESUME;
                end else if (period_end || wake_above_rising) begin
                    state_next.st       = LDCS_WAKE;
                    state_next.wake_cnt = 32'h0;
                    state_next.sample   = 1'b1;
                end
            end
            LDCS_RESUME: begin
                if (pll_locked) begin
                    state_next.st      = LDCS_NORMAL;
                    state_next.rot_dir = 1'b0;
                end
            end
            default: state_next.st = LDCS_NORMAL;
        endcase
    end

    // Registers all sequencer state.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            state_reg <= '0;
        end else if (clock_enable) begin
            state_reg <= state_next;
        end
    end

    // Pin drivers and power controls follow the state.
    always_comb begin
        logic lp;
        lp = (state_reg.st != LDCS_NORMAL);
        pwm_out             = pwm_level;
        pwm_oe              = !lp;
        miso_out            = miso_level;
        miso_oe             = !lp;
        commutation_outputs = commutation_level;
        commutation_oe      = !lp;
        power_ctrl.transducer_power   = (state_reg.st != LDCS_SLEEP);
        power_ctrl.lp_path_enable     = (state_reg.st == LDCS_WAKE);
        power_ctrl.pll_enable         = !lp || state_reg.st == LDCS_RESUME;
        power_ctrl.io_enable          = !lp;
        power_ctrl.angle_output_valid = !lp;
    end

    assign sample_request     = state_reg.sample;
    assign rotation_direction = state_reg.rot_dir;
    assign velocity           = state_reg.vel;
    assign lpm_state          = state_reg.st;

    ldcs_turns_counter u_turns (
        .clock            (clock),
        .nrst             (nrst),
        .enable           (clock_enable),
        .counter_clear    (turns_clear),
        .sample_valid     (lp_angle_valid && state_reg.st == LDCS_WAKE),
        .sample_angle     (lp_angle),
        .turn_step_select (config_in.turn_step_select),
        .turns_count      (turns_count),
        .turns_warning    (turns_warning)
    );

    lp_entry_a: assert property (@(posedge clock) disable iff (!nrst)
        (clock_enable && state_reg.st == LDCS_NORMAL && state_next.st == LDCS_WAKE)
        |-> (state_reg.pins_low && config_in.lpm_enable && !wake_above_falling))
        else $error("Low power entered without its conditions.");

    pins_released_a: assert property (@(posedge clock) disable iff (!nrst)
        (state_reg.st != LDCS_NORMAL) |-> (!pwm_oe && !miso_oe && !commutation_oe))
        else $error("Pin driven during low power.");

    sleep_power_a: assert property (@(posedge clock) disable iff (!nrst)
        (state_reg.st == LDCS_SLEEP) |-> !power_ctrl.transducer_power)
        else $error("Transducer powered in sleep.");

    sleep_boundary_a: assert property (@(posedge clock) disable iff (!nrst)
        (clock_enable && state_reg.st == LDCS_WAKE && state_next.st == LDCS_SLEEP)
        |-> period_end)
        else $error("Sleep entered off a period boundary.");

    fast_stays_a: assert property (@(posedge clock) disable iff (!nrst)
        (clock_enable && state_reg.st == LDCS_WAKE && state_reg.fast)
        |=> state_reg.st != LDCS_SLEEP)
        else $error("Slept while velocity above threshold.");

    wake_hold_a: assert property (@(posedge clock) disable iff (!nrst)
        (state_reg.st == LDCS_WAKE && wake_above_falling) |=> state_reg.st != LDCS_SLEEP)
        else $error("Slept while wake input high.");

    debounce_a: assert property (@(posedge clock) disable iff (!nrst)
        (clock_enable && any_pin_high) |=> !state_reg.pins_low)
        else $error("Pin-low flag survived a high pin.");

    resume_lock_a: assert property (@(posedge clock) disable iff (!nrst)
        (state_reg.st == LDCS_RESUME && !pll_locked) |=> state_reg.st != LDCS_NORMAL)
        else $error("Resumed before PLL lock.");

    sleep_exit_a: assert property (@(posedge clock) disable iff (!nrst)
        (clock_enable && state_reg.st == LDCS_SLEEP && !any_pin_high && wake_above_rising)
        |=> state_reg.st == LDCS_WAKE && sample_request)
        else $error("Wake input did not wake the sequencer.");

endmodule // ldcs_sequencer

// ==== verilog/ldcs_pkg.sv ====
package ldcs_pkg;

    // Clock rate and derived cycle counts.
    localparam int unsigned CLK_HZ            = 40_000_000;
    localparam int unsigned PIN_LOW_TIME_NS   = 64_000;
    localparam int unsigned WAKE_TIME_NS      = 160_000;
    localparam int unsigned CLK_PERIOD_NS     = 1_000_000_000 / CLK_HZ;
    localparam int unsigned PIN_LOW_CYCLES    = (PIN_LOW_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned WAKE_CYCLES       = WAKE_TIME_NS / CLK_PERIOD_NS;

    // Sleep period range in microseconds, 8.192 ms to 524 ms.
    localparam int unsigned SLEEP_MIN_US      = 8_192;
    localparam int unsigned SLEEP_MAX_US      = 524_000;
    localparam int unsigned SLEEP_MIN_CYCLES  = SLEEP_MIN_US * (CLK_HZ / 1_000_000);
    localparam int unsigned SLEEP_MAX_CYCLES  = SLEEP_MAX_US * (CLK_HZ / 1_000_000);

    // Angle and turns geometry.
    localparam int unsigned ANGLE_W           = 12;
    localparam int unsigned TURNS_W           = 12;
    localparam logic [11:0] TURNS_MAX_45      = 12'h7ff;
    localparam logic [11:0] TURNS_MIN_45      = 12'h800;
    localparam logic [11:0] TURNS_MAX_180     = 12'h1ff;
    localparam logic [11:0] TURNS_MIN_180     = 12'he00;
    localparam logic [11:0] TURNS_ONE         = 12'h001;
    localparam logic [2:0]  SECTOR_SHIFT_45   = 3'h0;
    localparam logic [2:0]  SECTOR_SHIFT_180  = 3'h2;

    typedef enum logic [1:0] {
        LDCS_NORMAL,
        LDCS_WAKE,
        LDCS_SLEEP,
        LDCS_RESUME
    } ldcs_state_type;

    // Configuration read live by the sequencer each cycle; nothing latches it.
    typedef struct packed {
        logic                 lpm_enable;
        logic                 turn_step_select;
        logic [ANGLE_W-1:0]   velocity_threshold;
        logic [31:0]          sleep_cycles;
    } ldcs_config_type;

    // Power and pin controls toward the rest of the device.
    typedef struct packed {
        logic transducer_power;
        logic lp_path_enable;
        logic pll_enable;
        logic io_enable;
        logic angle_output_valid;
    } ldcs_power_type;

endpackage

// ==== verilog/ldcs_turns_counter.sv ====
`timescale 1ns/1ps

module ldcs_turns_counter
    import ldcs_pkg::*;
(
    input  wire logic               clock,
    input  wire logic               nrst,
    input  wire logic               enable,
    input  wire logic               counter_clear,
    input  wire logic               sample_valid,
    input  wire logic [ANGLE_W-1:0] sample_angle,
    input  wire logic               turn_step_select,
    output logic [TURNS_W-1:0]      turns_count,
    output logic                    turns_warning
);

    typedef struct packed {
        logic [TURNS_W-1:0] count;
        logic               warn;
        logic [2:0]         sector;
        logic               primed;
    } ldcs_turns_type;

    ldcs_turns_type state_reg;
    ldcs_turns_type state_next;

    // Tracks the octant of the low-power angle and steps the signed count on 45 or 180 degree crossings, per turn_step_select.
    always_comb begin
        logic [2:0]         new_sector;
        logic [2:0]         diff;
        logic [2:0]         shift;
        logic [TURNS_W-1:0] hi;
        logic [TURNS_W-1:0] lo;
        logic               crossed;
        new_sector = sample_angle[ANGLE_W-1 -: 3];
        diff       = new_sector - state_reg.sector;
        shift      = turn_step_select ? SECTOR_SHIFT_45 : SECTOR_SHIFT_180;
        crossed    = (new_sector >> shift) != (state_reg.sector >> shift);
        hi         = turn_step_select ? TURNS_MAX_45 : TURNS_MAX_180;
        lo         = turn_step_select ? TURNS_MIN_45 : TURNS_MIN_180;
        state_next = state_reg;
        if (counter_clear) begin
            state_next.count = '0;
            state_next.warn  = 1'b0;
        end else if (sample_valid) begin
            state_next.primed = 1'b1;
            state_next.sector = new_sector;
            // The full octant is kept so that the step direction is known in both modes.
            // A step under half a turn counts forward, one over half a turn backward.
            if (state_reg.primed && crossed && !diff[2]) begin
                if (state_reg.count == hi) begin
                    state_next.warn = 1'b1;
                end else begin
                    state_next.count = state_reg.count + TURNS_ONE;
                end
            end else if (state_reg.primed && crossed && diff != 3'h4) begin
                if (state_reg.count == lo) begin
                    state_next.warn = 1'b1;
                end else begin
                    state_next.count = state_reg.count - TURNS_ONE;
                end
            end
        end
    end

    // Registers the counter state.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            state_reg <= '0;
        end else if (enable) begin
            state_reg <= state_next;
        end
    end

    assign turns_count   = state_reg.count;
    assign turns_warning = state_reg.warn;

    sat_sticky_a: assert property (@(posedge clock) disable iff (!nrst)
        (enable && state_reg.warn && !counter_clear) |=> state_reg.warn)
        else $error("Turns warning dropped without a counter reset.");

    sat_limit_a: assert property (@(posedge clock) disable iff (!nrst)
        (enable && !counter_clear && state_reg.count == TURNS_MAX_45 && turn_step_select)
        |=> state_reg.count != TURNS_MIN_45)
        else $error("Turns counter wrapped instead of saturating.");

endmodule // ldcs_turns_counter

// ==== verif/ldcs_host_model.sv ====
`timescale 1ns/1ps

// Host side of the SPI pins: idle keeps chip select high, a low-power request pulls all low.
module ldcs_host_model (
    input  wire logic clock,
    input  wire logic lp_request,
    input  wire logic blip,
    output logic      mosi,
    output logic      sclk,
    output logic      csn
);
    logic lp_q;
    logic blip_q;

    initial begin
        mosi = 1'b0;
        sclk = 1'b0;
        csn  = 1'b1;
    end

    // Requests are taken on the edge, then the pins change just after it.
    // A blip raises the clock pin for one cycle.
    always @(posedge clock) begin
        lp_q   = lp_request;
        blip_q = blip;
        #2;
        mosi = 1'b0;
        sclk = blip_q;
        csn  = !lp_q;
    end
endmodule // ldcs_host_model

// ==== verif/test_low_power_duty_cycle_sequencer.sv ====
`timescale 1ns/1ps

module test_low_power_duty_cycle_sequencer
    import ldcs_pkg::*;
;
    typedef struct packed {
        logic        tsel;
        logic [11:0] stp;
        logic [15:0] n;
        logic [11:0] exp;
        logic        warn;
    } ldcs_row_type;

    logic               clock, nrst, mosi, sclk, csn, lp_request, blip, clock_enable;
    logic               wake_above_rising, wake_above_falling, pll_locked;
    logic               logic_self_test, turns_clear, lp_angle_valid, pwm_level, miso_level;
    logic [ANGLE_W-1:0] lp_angle, velocity, ang;
    logic [2:0]         commutation_level, commutation_outputs;
    ldcs_config_type    config_in;
    logic               pwm_out, pwm_oe, miso_out, miso_oe, commutation_oe;
    logic               sample_request, rotation_direction, turns_warning;
    ldcs_power_type     power_ctrl;
    logic [TURNS_W-1:0] turns_count;
    ldcs_state_type     lpm_state;
    int                 failures, n_tests, n_req;
    ldcs_row_type       rows [7] = '{
        '{1'b1, 12'h200, 16'd5,    12'h005, 1'b0},
        '{1'b1, 12'he00, 16'd3,    12'hffd, 1'b0},
        '{1'b0, 12'h400, 16'd6,    12'h003, 1'b0},
        '{1'b0, 12'h400, 16'd1030, 12'h1ff, 1'b1},
        '{1'b0, 12'hc00, 16'd1030, 12'he00, 1'b1},
        '{1'b1, 12'h200, 16'd2060, 12'h7ff, 1'b1},
        '{1'b1, 12'he00, 16'd2060, 12'h800, 1'b1}};

    ldcs_host_model HOST (.clock, .lp_request, .blip, .mosi, .sclk, .csn);

    ldcs_sequencer #(.PIN_LOW_COUNT(4), .WAKE_COUNT(4), .SLEEP_MIN_COUNT(64)) DUT (
        .clock, .nrst, .clock_enable, .mosi, .sclk, .csn,
        .wake_above_rising, .wake_above_falling, .config_in, .pll_locked,
        .logic_self_test, .turns_clear, .lp_angle_valid, .lp_angle, .pwm_level,
        .miso_level, .commutation_level, .pwm_out, .pwm_oe, .miso_out, .miso_oe,
        .commutation_outputs, .commutation_oe, .power_ctrl, .sample_request,
        .rotation_direction, .velocity, .turns_count, .turns_warning, .lpm_state);

    // The clock toggles every half period of 12.5 ns.
    initial begin
        clock = 1'b0;
        forever #12.5 clock = !clock;
    end

    // Sample request pulses are counted as they appear.
    always @(posedge clock) begin
        if (sample_request === 1'b1) n_req++;
    end

    // A hang is cut short well after the expected run length.
    initial begin
        #1000000;
        failures++;
        close_out();
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge clock);
        #2;
    endtask

    // Steps until the sequencer reaches a state, giving up after a bound.
    task automatic wait_state(input ldcs_state_type s);
        for (int i = 0; i < 300 && lpm_state != s; i++) begin
            step(1);
        end
        check(lpm_state, s);
    endtask

    // One low-power path sample, valid for a single cycle.
    task automatic feed(input logic [11:0] a);
        lp_angle = a;
        lp_angle_valid = 1'b1;
        step(1);
        lp_angle_valid = 1'b0;
        step(1);
    endtask

    task automatic close_out;
        $display("failures=%0d n_tests=%0d", failures, n_tests);
        if (failures == 0 && n_tests > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    // Main sequence: reset, entry, turns table, then exit.
    initial begin
        {nrst, lp_request, blip, wake_above_rising, wake_above_falling} = 5'h00;
        {logic_self_test, turns_clear, lp_angle_valid, lp_angle} = 15'h0000;
        {pwm_level, miso_level, commutation_level} = 5'h15;
        pll_locked = 1'b1;
        clock_enable = 1'b1;
        config_in = '{1'b1, 1'b1, 12'h100, 32'h0000_0100};
        ang = 12'h000;
        step(8);
        nrst = 1'b1;
        check(lpm_state, LDCS_NORMAL);
        check(power_ctrl, 5'h17);
        check({pwm_oe, miso_oe, commutation_oe, pwm_out, miso_out, commutation_outputs}, 8'hf5);
        check({turns_count, turns_warning, rotation_direction}, 14'h0000);
        config_in.lpm_enable = 1'b0;
        lp_request = 1'b1;
        step(10);
        check(lpm_state, LDCS_NORMAL);
        config_in.lpm_enable = 1'b1;
        {wake_above_rising, wake_above_falling} = 2'h3;
        step(10);
        check(lpm_state, LDCS_NORMAL);
        // Pins go high before the wake input drops, so entry stays refused.
        lp_request = 1'b0;
        step(3);
        {wake_above_rising, wake_above_falling} = 2'h0;
        // A pin rising mid-count restarts the debounce.
        lp_request = 1'b1;
        step(2);
        blip = 1'b1;
        step(1);
        blip = 1'b0;
        step(4);
        check(lpm_state, LDCS_NORMAL);
        pll_locked = 1'b0;
        step(8);
        check(lpm_state, LDCS_WAKE);
        check({pwm_oe, miso_oe, commutation_oe, pwm_oe ? pwm_out : 1'b1}, 4'h1);
        check(power_ctrl, 5'h18);
        check(n_req != 0, 1);
        // The wake input holds the sequencer awake across period boundaries.
        wake_above_falling = 1'b1;
        feed(12'h100);
        check(velocity, 12'h000);
        feed(12'hf00);
        check(velocity, 12'h200);
        feed(12'h000);
        check(velocity, 12'h100);
        // Each row clears the count, then turns the magnet by fixed steps.
        foreach (rows[i]) begin
            config_in.turn_step_select = rows[i].tsel;
            turns_clear = 1'b1;
            step(1);
            turns_clear = 1'b0;
            for (int k = 0; k < rows[i].n; k++) begin
                ang = ang + rows[i].stp;
                feed(ang);
            end
            check(turns_count, rows[i].exp);
            check(turns_warning, rows[i].warn);
            check(lpm_state, LDCS_WAKE);
        end
        turns_clear = 1'b1;
        step(1);
        turns_clear = 1'b0;
        check({turns_count, turns_warning}, 13'h0000);
        check(rotation_direction, 1'b1);
        logic_self_test = 1'b1;
        step(1);
        logic_self_test = 1'b0;
        check(rotation_direction, 1'b0);
        // A slow backward step lets the sequencer sleep at the next boundary.
        feed(ang - 12'h010);
        check(rotation_direction, 1'b1);
        wake_above_falling = 1'b0;
        wait_state(LDCS_SLEEP);
        check(power_ctrl, 5'h00);
        // A low clock enable freezes the period counter and the state.
        clock_enable = 1'b0;
        step(300);
        check(lpm_state, LDCS_SLEEP);
        clock_enable = 1'b1;
        wait_state(LDCS_WAKE);
        check(sample_request, 1'b1);
        wait_state(LDCS_SLEEP);
        {wake_above_rising, wake_above_falling} = 2'h3;
        step(1);
        check({lpm_state, sample_request}, {LDCS_WAKE, 1'b1});
        step(300);
        check(lpm_state, LDCS_WAKE);
        {wake_above_rising, wake_above_falling} = 2'h0;
        // Releasing the pins resumes, but only once the PLL reports lock.
        lp_request = 1'b0;
        step(3);
        check(lpm_state, LDCS_RESUME);
        check({power_ctrl.pll_enable, power_ctrl.angle_output_valid, pwm_oe}, 3'h4);
        step(5);
        check(lpm_state, LDCS_RESUME);
        pll_locked = 1'b1;
        step(2);
        check(lpm_state, LDCS_NORMAL);
        check({rotation_direction, pwm_oe, power_ctrl.angle_output_valid}, 3'h3);
        logic_self_test = 1'b1;
        step(1);
        logic_self_test = 1'b0;
        check(rotation_direction, 1'b0);
        close_out();
    end
endmodule // test_low_power_duty_cycle_sequencer
